// ---- src/pms_sequencer.sv ----
/*
  pms_sequencer: power state machine, pulsed-led proximity accumulation on the
  front-end clock, conversion scaling, result bytes and threshold interrupt.
  Assumes settings are driven synchronously to clk by the host-side logic and
  photodiode samples arrive synchronously to link_clk.
*/
// Functional notes
// - after reset stay asleep, no measurement until power-on bit set
// - power-on bit is bit 0 of enable register 0
// - power-on from sleep waits one 2.72 ms start delay, then start
// - power-on cleared: finish running conversion, then go to sleep
// - cycle proximity and wait phases, each only when its enable is set
// - proximity: accumulate, then conversion, then wait-check
// - wait-check enters wait only when wait enable is set
// - wait lasts 256 minus setting steps; setting 0xFF gives one step
// - long-wait bit stretches each wait twelvefold
// - after wait, one 2.72 ms wait delay, then back to start
// - led current selectable 100, 50, 25 or 12.5 percent
// - drive field: 0 full, 1 half, 2 quarter, 3 eighth
// - led pulses 7.3 us on, 16.0 us period, accumulate only
// - zero to 255 led pulses per measurement; zero gives no pulses and a zero result
// - add led-on integral, subtract equal background, accumulate over pulses
// - result scaled to 16 bits, held as two bytes
// - conversion lasts 256 minus setting units of 2.73 ms
// - interrupt generation gated by interrupt enable bit
// - event when result above upper or below lower threshold
// - interrupt only after event persists for programmed conversions
// - interrupt stays pending until host clear command
`default_nettype none
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int SAMPLE_W  = 10,
  parameter int STEP_CYCLES = pms_pkg::STEP_CYC,
  parameter int CONV_CYCLES = pms_pkg::CONV_UNIT_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                link_clk,
  input  wire logic [7:0]          enable_reg,
  input  wire logic                long_wait_bit,
  input  wire logic [7:0]          wait_time_setting,
  input  wire logic [7:0]          conversion_time_setting,
  input  wire logic [7:0]          led_pulse_count,
  input  wire logic [1:0]          led_drive_strength,
  input  wire logic [1:0]          photodiode_select,
  input  wire logic [15:0]         upper_threshold,
  input  wire logic [15:0]         lower_threshold,
  input  wire logic [3:0]          persistence_count,
  input  wire logic                int_clear,
  input  wire logic [SAMPLE_W-1:0] photodiode_a,
  input  wire logic [SAMPLE_W-1:0] photodiode_b,
  output var  pms_pkg::pms_result_t prox_result_bytes,
  output logic                     prox_irq,
  output logic                     seq_active,
  output logic                     led_sink_pin,
  output logic [7:0]               led_current_legs
);
  import pms_pkg::*;

  localparam int TMR_W = 20;
  localparam int ACC_W = 24;
  localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(STEP_CYCLES - 1);
  localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_CYCLES - 1);
  localparam logic [6:0] LED_ON_L  = 7'(LED_ON_CYC);
  localparam logic [6:0] LED_PER_L = 7'(LED_PERIOD_CYC - 1);

  // 1..256 steps from a down-counting setting
  function automatic logic [8:0] span(input logic [7:0] s);
    span = 9'h100 - {1'b0, s};
  endfunction

  function automatic logic [15:0] sat16(input logic [ACC_W-1:0] v);
    if (v[ACC_W-1]) sat16 = 16'h0000;
    else if (|v[ACC_W-2:16]) sat16 = 16'hFFFF;
    else sat16 = v[15:0];
  endfunction

  wire logic power_on  = enable_reg[PON_BIT];
  wire logic prox_en   = enable_reg[PEN_BIT];
  wire logic wait_en   = enable_reg[WEN_BIT];
  wire logic prox_ien  = enable_reg[PROX_INTERRUPT_ENABLE_BIT];

  // ---- system clock domain ----
  pms_state_t       state_q, state_d;
  logic [TMR_W-1:0] tmr_q;
  logic [11:0]      units_q;
  logic             req_tgl_q;
  pms_acc_cmd_t     cmd_q;
  logic             done_s1_q, done_s2_q, done_s3_q;
  logic [15:0]      acc_cap_q;
  pms_result_t      result_q;
  logic [3:0]       pers_q;
  logic             irq_q;
  logic             active_q;
  logic [7:0]       legs_q;

  // ---- link domain ----
  logic              lrst_s1_q, lrst_q;
  logic              req_s1_q, req_s2_q, req_s3_q;
  logic              busy_q;
  logic [7:0]        pcnt_q;
  logic [6:0]        phase_q;
  logic [1:0]        ldiode_q;
  logic [ACC_W-1:0]  acc_q;
  logic [15:0]       acc_word_q;
  logic              done_tgl_q;
  logic              led_q;

  wire logic done_evt = done_s2_q ^ done_s3_q;
  wire logic [8:0] conv_units = span(conversion_time_setting);
  wire logic [11:0] wait_steps = long_wait_bit ?
      12'(span(wait_time_setting) * 12'(LONG_WAIT_FACTOR)) : {3'h0, span(wait_time_setting)};
  wire logic tick = (state_q == ST_PROX_CONV) ? (tmr_q == CONV_LAST) : (tmr_q == STEP_LAST);
  wire logic conv_done = (state_q == ST_PROX_CONV) && tick &&
                         (units_q == 12'(conv_units - 9'h001));
  wire logic wait_done = (state_q == ST_WAIT) && tick &&
                         (units_q == wait_steps - 12'h001);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP:     if (power_on) state_d = ST_START_DLY;
      ST_START_DLY: begin
        if (!power_on) state_d = ST_SLEEP;
        else if (tick) state_d = ST_START;
      end
      ST_START: begin
        if (!power_on) state_d = ST_SLEEP;
        else if (prox_en) state_d = ST_PROX_ACC;
        else state_d = ST_WAIT_CHK;
      end
      ST_PROX_ACC:  if (done_evt) state_d = ST_PROX_CONV;
      ST_PROX_CONV: if (conv_done) state_d = ST_WAIT_CHK;
      ST_WAIT_CHK: begin
        if (!power_on) state_d = ST_SLEEP;
        else if (wait_en) state_d = ST_WAIT;
        else state_d = ST_START;
      end
      ST_WAIT: begin
        // a wait is not a conversion, so power-off may cut it short
        if (!power_on) state_d = ST_SLEEP;
        else if (wait_done) state_d = ST_WAIT_DLY;
      end
      ST_WAIT_DLY:  if (tick) state_d = ST_START;
      default:      state_d = ST_SLEEP;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_q <= ST_SLEEP;
    else state_q <= state_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_q   <= '0;
      units_q <= '0;
    end else if (state_d != state_q) begin
      tmr_q   <= '0;
      units_q <= '0;
    end else if (tick) begin
      tmr_q   <= '0;
      units_q <= units_q + 12'h001;
    end else begin
      tmr_q   <= tmr_q + TMR_W'(1);
    end
  end

  // launch an accumulation; cmd stays still until the done toggle returns
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_tgl_q <= 1'b0;
      cmd_q     <= '0;
    end else if (state_q == ST_START && state_d == ST_PROX_ACC) begin
      req_tgl_q <= ~req_tgl_q;
      cmd_q     <= '{pulses: led_pulse_count, diode: photodiode_select};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      acc_cap_q <= '0;
    end else begin
      done_s1_q <= done_tgl_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      if (done_evt) acc_cap_q <= acc_word_q;
    end
  end

  wire logic [24:0] scaled = 25'(acc_cap_q) * 25'(conv_units);
  wire logic [15:0] res_new = (|scaled[24:16]) ? 16'hFFFF : scaled[15:0];
  wire logic out_of_band = (res_new > upper_threshold) || (res_new < lower_threshold);
  wire logic [3:0] pers_next = out_of_band ? ((pers_q == 4'hF) ? 4'hF : pers_q + 4'h1) : 4'h0;
  wire logic irq_set = conv_done && prox_ien && out_of_band &&
                       (pers_next >= persistence_count);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= RESULT_RST;
      pers_q   <= '0;
    end else if (conv_done) begin
      result_q <= res_new;
      pers_q   <= pers_next;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_q <= 1'b0;
    else if (irq_set) irq_q <= 1'b1;
    else if (int_clear) irq_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
      legs_q   <= LEGS_RST;
    end else begin
      active_q <= (state_q != ST_SLEEP);
      case (led_drive_strength)
        2'h0:    legs_q <= 8'hFF;
        2'h1:    legs_q <= 8'h0F;
        2'h2:    legs_q <= 8'h03;
        default: legs_q <= 8'h01;
      endcase
    end
  end

  // ---- link domain: reset and request crossing ----
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lrst_s1_q <= 1'b1;
      lrst_q    <= 1'b1;
    end else begin
      lrst_s1_q <= 1'b0;
      lrst_q    <= lrst_s1_q;
    end
  end

  always_ff @(posedge link_clk or posedge lrst_q) begin
    if (lrst_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  wire logic l_start = req_s2_q ^ req_s3_q;
  // no diode chosen leaves the integrator starved
  wire logic [SAMPLE_W-1:0] sample = (ldiode_q == PD_A) ? photodiode_a :
                                     (ldiode_q == PD_B) ? photodiode_b : '0;
  wire logic last_phase = (phase_q == LED_PER_L);

  always_ff @(posedge link_clk or posedge lrst_q) begin
    if (lrst_q) begin
      busy_q     <= 1'b0;
      pcnt_q     <= '0;
      phase_q    <= '0;
      ldiode_q   <= PD_NONE;
      acc_q      <= '0;
      acc_word_q <= '0;
      done_tgl_q <= 1'b0;
    end else if (l_start) begin
      ldiode_q <= cmd_q.diode;
      pcnt_q   <= cmd_q.pulses;
      phase_q  <= '0;
      acc_q    <= '0;
      if (cmd_q.pulses == 8'h00) begin
        acc_word_q <= '0;
        done_tgl_q <= ~done_tgl_q;
      end else begin
        busy_q <= 1'b1;
      end
    end else if (busy_q) begin
      // equal-length background window cancels ambient light
      if (phase_q < LED_ON_L)
        acc_q <= acc_q + ACC_W'(sample);
      else if (phase_q < 7'(2 * LED_ON_CYC))
        acc_q <= acc_q - ACC_W'(sample);
      phase_q <= last_phase ? 7'h00 : phase_q + 7'h01;
      if (last_phase) begin
        pcnt_q <= pcnt_q - 8'h01;
        if (pcnt_q == 8'h01) begin
          busy_q     <= 1'b0;
          acc_word_q <= sat16(acc_q);
          done_tgl_q <= ~done_tgl_q;
        end
      end
    end
  end

  always_ff @(posedge link_clk or posedge lrst_q) begin
    if (lrst_q) led_q <= 1'b0;
    else led_q <= busy_q && (phase_q < LED_ON_L);
  end

  assign prox_result_bytes = result_q;
  assign prox_irq          = irq_q;
  assign seq_active        = active_q;
  assign led_sink_pin      = led_q;
  assign led_current_legs  = legs_q;

  // ---- checks ----
  a_sleep_holds: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_SLEEP && !power_on |=> state_q == ST_SLEEP)
    else $error("left sleep without power-on");
  a_start_delay_len: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_START_DLY && state_d == ST_START |-> tmr_q == STEP_LAST)
    else $error("start delay wrong length");
  a_conv_finish: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_PROX_CONV && !conv_done |=> state_q == ST_PROX_CONV)
    else $error("conversion cut short");
  a_prox_skip: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_START && power_on && !prox_en |=> state_q == ST_WAIT_CHK)
    else $error("disabled proximity phase not skipped");
  a_acc_to_conv: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_PROX_ACC ##1 state_q != ST_PROX_ACC |-> state_q == ST_PROX_CONV)
    else $error("accumulate not followed by conversion");
  a_wait_gate: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_WAIT_CHK && power_on && !wait_en |=> state_q == ST_START)
    else $error("wait entered while disabled");
  a_wait_length: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_WAIT && state_d == ST_WAIT_DLY |->
      units_q == wait_steps - 12'h001 && tmr_q == STEP_LAST)
    else $error("wait length wrong");
  a_long_factor: assert property (@(posedge clk) disable iff (rst)
    long_wait_bit |-> wait_steps == 12'((12'h100 - {4'h0, wait_time_setting}) * 12'h00C))
    else $error("long wait factor wrong");
  a_wait_dly_exit: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_WAIT_DLY ##1 state_q != ST_WAIT_DLY |-> state_q == ST_START)
    else $error("wait delay exit wrong");
  a_led_in_acc: assert property (@(posedge link_clk) disable iff (lrst_q)
    led_q |-> $past(busy_q))
    else $error("led pulse outside accumulation");
  a_result_at_end: assert property (@(posedge clk) disable iff (rst)
    $changed(result_q) |-> $past(conv_done))
    else $error("result changed outside conversion end");
  a_irq_enable: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_q) |-> $past(prox_ien) && $past(out_of_band))
    else $error("interrupt raised while disabled");
  a_irq_sticky: assert property (@(posedge clk) disable iff (rst)
    irq_q && !int_clear |=> irq_q)
    else $error("interrupt dropped without clear");

  c_wait_entered: cover property (@(posedge clk) disable iff (rst)
    state_q == ST_WAIT_CHK ##1 state_q == ST_WAIT);
  c_irq_raised: cover property (@(posedge clk) disable iff (rst) $rose(irq_q));
  c_conv_done: cover property (@(posedge clk) disable iff (rst) conv_done);
  c_back_to_sleep: cover property (@(posedge clk) disable iff (rst)
    state_q == ST_WAIT_CHK ##1 state_q == ST_SLEEP);

endmodule
`default_nettype wire

// ---- pkg/pms_pkg.sv ----
/*
  pms_pkg: constants, field positions, timing counts and carrier types of the
  proximity measurement sequencer.
  Assumes a 20 MHz system clock and a 8 MHz front-end (link) clock.
*/
`default_nettype none
package pms_pkg;

  // clock periods
  localparam int CLK_NS  = 50;
  localparam int LINK_NS = 125;

  // sequencer time steps, in ns as specified
  localparam int STEP_NS      = 2_720_000;
  localparam int CONV_UNIT_NS = 2_730_000;
  localparam int STEP_CYC      = STEP_NS / CLK_NS;
  localparam int CONV_UNIT_CYC = CONV_UNIT_NS / CLK_NS;

  // led pulse shape on the link clock
  localparam int LED_ON_NS      = 7_300;
  localparam int LED_PERIOD_NS  = 16_000;
  localparam int LED_ON_CYC     = (LED_ON_NS + LINK_NS - 1) / LINK_NS;
  localparam int LED_PERIOD_CYC = LED_PERIOD_NS / LINK_NS;

  localparam int LONG_WAIT_FACTOR = 12;

  // enable register (register 0) bit positions
  localparam int ENABLE_REG_IDX = 0;
  localparam int PON_BIT        = 0;
  localparam int PEN_BIT        = 2;
  localparam int WEN_BIT        = 3;
  localparam int PROX_INTERRUPT_ENABLE_BIT       = 5;

  // photodiode selector encodings
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_A    = 2'h1;
  localparam logic [1:0] PD_B    = 2'h2;

  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0]  LEGS_RST   = 8'h00;

  typedef enum logic [2:0] {
    ST_SLEEP, ST_START_DLY, ST_START, ST_PROX_ACC,
    ST_PROX_CONV, ST_WAIT_CHK, ST_WAIT, ST_WAIT_DLY
  } pms_state_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } pms_result_t;

  typedef struct packed {
    logic [7:0] pulses;
    logic [1:0] diode;
  } pms_acc_cmd_t;

endpackage
`default_nettype wire

// ---- sim/pms_frontend_model.sv ----
/*
  pms_frontend_model: photodiode front end facing the sequencer; diode a sees
  background plus led reflection, diode b background only.
  Assumes led_sink_pin is registered on link_clk.
*/
`default_nettype none
module pms_frontend_model #(
  parameter int                  SAMPLE_W = 10,
  parameter logic [SAMPLE_W-1:0] BG       = 10'h040,
  parameter logic [SAMPLE_W-1:0] REFL     = 10'h010
) (
  input  wire logic                link_clk,
  input  wire logic                led_sink_pin,
  output logic [SAMPLE_W-1:0]      photodiode_a,
  output logic [SAMPLE_W-1:0]      photodiode_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // background never drops, so any subtraction slip leaves a residue
  always @(posedge link_clk) begin
    photodiode_a <= BG + (led_sink_pin ? REFL : '0);
    photodiode_b <= BG;
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
  tb_top: self-checking bench for pms_sequencer with a front-end model.
  Assumes shortened step and conversion counts; led timing seen at the pin.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pms_pkg::*;
  localparam int STEP = 20;
  localparam int CONV = 300;
  logic clk, rst, link_clk, long_wait_bit, int_clear, prox_irq, seq_active, led_sink_pin;
  logic [7:0]  enable_reg, wait_time_setting, conversion_time_setting, led_pulse_count;
  logic [7:0]  led_current_legs;
  logic [1:0]  led_drive_strength, photodiode_select;
  logic [15:0] upper_threshold, lower_threshold, r1;
  logic [3:0]  persistence_count;
  logic [9:0]  photodiode_a, photodiode_b;
  pms_result_t prox_result_bytes;
  logic        led_s;
  int err_count, checks, cyc, last_rise, cur_start, prev_start, burst_cnt;
  int on_w, last_w, per_w, last_p, pulse_n, t0, p0, d, k, b;
  logic [7:0] legs_tab [4] = '{8'hff, 8'h0f, 8'h03, 8'h01};
  logic [7:0] wt_tab [3] = '{8'hff, 8'hfe, 8'hff};
  int         extra_tab [3] = '{2 * STEP, 3 * STEP, 13 * STEP};

  pms_sequencer #(.SAMPLE_W(10), .STEP_CYCLES(STEP), .CONV_CYCLES(CONV)) dut_u (
    .clk(clk), .rst(rst), .link_clk(link_clk), .enable_reg(enable_reg),
    .long_wait_bit(long_wait_bit), .wait_time_setting(wait_time_setting),
    .conversion_time_setting(conversion_time_setting), .led_pulse_count(led_pulse_count),
    .led_drive_strength(led_drive_strength), .photodiode_select(photodiode_select),
    .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
    .persistence_count(persistence_count), .int_clear(int_clear),
    .photodiode_a(photodiode_a), .photodiode_b(photodiode_b),
    .prox_result_bytes(prox_result_bytes), .prox_irq(prox_irq), .seq_active(seq_active),
    .led_sink_pin(led_sink_pin), .led_current_legs(led_current_legs));
  pms_frontend_model #(.SAMPLE_W(10)) fe_u (.link_clk(link_clk), .led_sink_pin(led_sink_pin),
    .photodiode_a(photodiode_a), .photodiode_b(photodiode_b));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  // burst start: an led rise with no other rise for 400 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    led_s <= led_sink_pin;
    if (led_sink_pin && !led_s) begin
      last_rise <= cyc;
      if (cyc - last_rise > 400) begin
        burst_cnt <= burst_cnt + 1;
        prev_start <= cur_start;
        cur_start <= cyc;
      end
    end
  end
  always @(posedge link_clk) begin
    per_w <= (led_sink_pin && on_w == 0) ? 1 : per_w + 1;
    if (led_sink_pin && on_w == 0) last_p <= per_w;
    if (led_sink_pin) on_w <= on_w + 1;
    else if (on_w != 0) begin
      last_w <= on_w;
      on_w <= 0;
      pulse_n <= pulse_n + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_bursts(input int n);
    int tgt;
    tgt = burst_cnt + n;
    for (int i = 0; i < 6000 * n && burst_cnt < tgt; i++) @(negedge clk);
    if (burst_cnt < tgt) begin
      err_count++;
      finish_test();
    end
  endtask
  // period between the last two bursts, once settings have settled
  task automatic period(output int p);
    wait_bursts(2);
    p = cur_start - prev_start;
  endtask

  initial begin
    {rst, enable_reg, long_wait_bit} = {1'b1, 8'h00, 1'b0};
    {int_clear, persistence_count} = {1'b0, 4'h0};
    {wait_time_setting, conversion_time_setting, led_pulse_count} = {8'hff, 8'hff, 8'h03};
    {led_drive_strength, photodiode_select} = {2'h0, PD_B};
    {upper_threshold, lower_threshold} = {16'hffff, 16'h0001};
    {err_count, checks, cyc, burst_cnt, on_w, per_w, pulse_n} = '0;
    // far in the past so the very first led rise opens a burst
    last_rise = -1000;
    {cur_start, prev_start, last_w, last_p} = '0;
    // held longer than two cycles so the link domain sees three edges
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(prox_result_bytes, RESULT_RST);
    chk({prox_irq, seq_active, led_sink_pin}, 16'h0000);
    for (k = 0; k < 4; k++) begin
      led_drive_strength = 2'(k);
      repeat (2) @(negedge clk);
      chk(led_current_legs, legs_tab[k]);
    end
    repeat (100) @(negedge clk);
    chk({seq_active, 8'(burst_cnt)}, 16'h0000);
    persistence_count = 4'h3;
    enable_reg = 8'h25;
    t0 = cyc;
    wait_bursts(1);
    chk(16'(cur_start - t0 > STEP), 16'h0001);
    chk(seq_active, 16'h0001);
    wait_bursts(1);
    chk(16'(pulse_n), 16'h0003);
    chk(16'(last_w), 16'(LED_ON_CYC));
    chk(16'(last_p), 16'(LED_PERIOD_CYC));
    chk(prox_result_bytes, 16'h0000);
    chk(prox_irq, 16'h0000);
    wait_bursts(1);
    chk(prox_irq, 16'h0000);
    wait_bursts(1);
    chk(prox_irq, 16'h0001);
    int_clear = 1'b1;
    @(negedge clk);
    int_clear = 1'b0;
    @(negedge clk);
    chk(prox_irq, 16'h0000);
    enable_reg = 8'h05;
    wait_bursts(2);
    chk(prox_irq, 16'h0000);
    period(p0);
    for (k = 0; k < 3; k++) begin
      wait_time_setting = wt_tab[k];
      long_wait_bit = (k == 2);
      enable_reg = 8'h0d;
      period(d);
      d = d - p0 - extra_tab[k];
      chk(16'(d >= -4 && d <= 4), 16'h0001);
    end
    // proximity off: sequencer keeps cycling but never pulses the led
    enable_reg = 8'h01;
    b = burst_cnt;
    repeat (3000) @(negedge clk);
    chk(16'(burst_cnt - b), 16'h0000);
    chk(seq_active, 16'h0001);
    enable_reg = 8'h05;
    {photodiode_select, upper_threshold} = {PD_A, 16'h0000};
    period(p0);
    r1 = prox_result_bytes;
    chk(16'(r1 != 0 && r1 <= 16'h0b10), 16'h0001);
    conversion_time_setting = 8'hfe;
    period(d);
    chk(prox_result_bytes, 16'(r1 * 2));
    d = d - p0 - CONV;
    chk(16'(d >= -4 && d <= 4), 16'h0001);
    wait_bursts(1);
    enable_reg = 8'h04;
    b = burst_cnt;
    repeat (200) @(negedge clk);
    chk(seq_active, 16'h0001);
    for (k = 0; k < 3000 && seq_active !== 1'b0; k++) @(negedge clk);
    chk(seq_active, 16'h0000);
    chk(prox_result_bytes, 16'(r1 * 2));
    repeat (3000) @(negedge clk);
    chk(16'(burst_cnt - b), 16'h0000);
    // no diode chosen: reflection must not reach the result
    photodiode_select = PD_NONE;
    enable_reg = 8'h05;
    wait_bursts(2);
    chk(prox_result_bytes, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
